// ==== inc/tcsc_cfg.svh ====
// register offsets, field positions and reset values of the channel block
`ifndef TCSC_CFG_SVH
`define TCSC_CFG_SVH
`define TCSC_OFF_CSC 4'h0
`define TCSC_OFF_CTRL 4'h4
`define TCSC_OFF_STAT 4'h8
`define TCSC_BIT_FLAG 7
`define TCSC_BIT_IRQ_EN 6
`define TCSC_BIT_MODE_HI 5
`define TCSC_BIT_MODE_LO 4
`define TCSC_BIT_EDGE_HI 3
`define TCSC_BIT_EDGE_LO 2
`define TCSC_BIT_WRITE_PROTECT_DISABLE 0
`define TCSC_RST_CSC 8'h00
`define TCSC_RST_WRITE_PROTECT_DISABLE 1'b0
`endif

// ==== inc/tcsc_pkg.sv ====
// types shared by the channel status-control block
package tcsc_pkg;
  // bus write handshake states, gray along the usual path
  typedef enum logic [1:0]
  {
    TCSC_W_IDLE = 2'b00,
    TCSC_W_RESP = 2'b01
  } tcsc_wstate_t;
  // edge detection choice decoded from the two select bits
  typedef enum logic [1:0]
  {
    TCSC_EDGE_OFF = 2'b00,
    TCSC_EDGE_RISE = 2'b01,
    TCSC_EDGE_FALL = 2'b10,
    TCSC_EDGE_BOTH = 2'b11
  } tcsc_edge_t;
endpackage

// ==== hdl/tcsc_channel.sv ====
// channel status-control register with event flag, behind axi4-lite
// How it works
// (RL1) reserved bits read zero, writes ignored
// (RL2) hardware event sets flag bit 7
// (RL3) flag clears on read-while-set then zero-write
// (RL4) writing one to flag changes nothing
// (RL5) event between read and write keeps flag
// (RL6) bit 6 enables channel interrupt
// (RL7) bits 5:4 select channel mode
// (RL8) bits 3:2 edge/level select, mode dependent
// (RL9) select bits writable only when unprotected
// (RL10) dual edge: 00 off, 01 rise, 10 fall, 11 both
// (RL11) irq while flag and enable both set
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "tcsc_cfg.svh"
module tcsc_channel
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic channel_event,
  input wire logic dual_edge_mode,
  input wire logic channel_pin,
  output logic channel_port_enable,
  output logic [1:0] mode_select,
  output logic [1:0] edge_level_select,
  output logic channel_irq
);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic channel_event_flag;
  logic channel_irq_enable;
  logic mode_select_hi;
  logic mode_select_lo;
  logic edge_level_select_hi;
  logic edge_level_select_lo;
  logic write_protect_disable;
  logic clear_armed;
  logic pin_q;
  logic dual_edge_seen;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  tcsc_pkg::tcsc_wstate_t wstate;
  tcsc_pkg::tcsc_wstate_t next_wstate;
  // register reset image, so the flag reset is a one-bit pick of it
  localparam logic [7:0] rst_csc = `TCSC_RST_CSC;
  ////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] o);
    addr_is = (a == o);
  endfunction
  wire [3:0] ar_off = s_axi_araddr[3:0];
  wire ar_csc = addr_is(ar_off, `TCSC_OFF_CSC);
  wire ar_ctrl = addr_is(ar_off, `TCSC_OFF_CTRL);
  wire ar_stat = addr_is(ar_off, `TCSC_OFF_STAT);
  wire ar_hit = ar_csc | ar_ctrl | ar_stat;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  // write fires once both address and data are held
  wire wr_fire = aw_held & w_held & (wstate == tcsc_pkg::TCSC_W_IDLE);
  wire wr_csc = wr_fire & addr_is(aw_addr_q, `TCSC_OFF_CSC) & w_strb_q[0];
  wire wr_ctrl = wr_fire & addr_is(aw_addr_q, `TCSC_OFF_CTRL) & w_strb_q[0];
  wire wr_hit = addr_is(aw_addr_q, `TCSC_OFF_CSC)
    | addr_is(aw_addr_q, `TCSC_OFF_CTRL) | addr_is(aw_addr_q, `TCSC_OFF_STAT);
  wire [7:0] csc_view = {channel_event_flag, channel_irq_enable,
    mode_select_hi, mode_select_lo, edge_level_select_hi,
    edge_level_select_lo, 2'b00}; // RL1
  wire [7:0] stat_view = {6'h00, dual_edge_seen, channel_event_flag};
  // zero-write only clears after an armed read and with no new event
  wire flag_zero_wr = wr_csc & ~w_data_q[`TCSC_BIT_FLAG]; // RL4
  wire flag_clear = flag_zero_wr & clear_armed & ~channel_event; // RL3 RL5
  wire sel_wr = wr_csc & write_protect_disable; // RL9
  ////////////////////////////////////////////////////////////////////////
  // dual edge detection from the pin
  wire pin_rise = channel_pin & ~pin_q;
  wire pin_fall = ~channel_pin & pin_q;
  wire [1:0] els = {edge_level_select_hi, edge_level_select_lo};
  wire edge_hit = (els == tcsc_pkg::TCSC_EDGE_RISE) ? pin_rise
    : (els == tcsc_pkg::TCSC_EDGE_FALL) ? pin_fall
    : (els == tcsc_pkg::TCSC_EDGE_BOTH) ? (pin_rise | pin_fall)
    : 1'b0; // RL10
  wire event_in = channel_event | (dual_edge_mode & edge_hit);
  ////////////////////////////////////////////////////////////////////////
  // handshake outputs
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  assign s_axi_bvalid = (wstate == tcsc_pkg::TCSC_W_RESP);
  assign next_wstate = wr_fire ? tcsc_pkg::TCSC_W_RESP
    : (s_axi_bvalid & s_axi_bready) ? tcsc_pkg::TCSC_W_IDLE : wstate;
  assign mode_select = {mode_select_hi, mode_select_lo}; // RL7
  assign edge_level_select = els; // RL8
  assign channel_port_enable = ~dual_edge_mode
    | (els != tcsc_pkg::TCSC_EDGE_OFF); // RL10
  assign channel_irq = channel_event_flag & channel_irq_enable; // RL11 RL6
  ////////////////////////////////////////////////////////////////////////
  // write channel capture
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      wstate <= tcsc_pkg::TCSC_W_IDLE;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      wstate <= next_wstate;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr[3:0];
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
      if (wr_fire)
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10; // unmapped gives slverr
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // read channel, one cycle after the address is taken
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, ar_csc ? csc_view : ar_stat ? stat_view
        : ar_ctrl ? {7'h00, write_protect_disable} : 8'h00}; // RL1
      s_axi_rresp <= ar_hit ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // flag and its clear arming; a set always wins over a clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_event_flag <= rst_csc[`TCSC_BIT_FLAG];
      clear_armed <= 1'b0;
      pin_q <= 1'b0;
      dual_edge_seen <= 1'b0;
    end
    else
    begin
      pin_q <= channel_pin;
      if (event_in)
        channel_event_flag <= 1'b1; // RL2
      else if (flag_clear)
        channel_event_flag <= 1'b0; // RL3
      // a fresh event disarms so the pending write does nothing
      if (event_in | flag_zero_wr)
        clear_armed <= 1'b0; // RL5
      else if (ar_take & (ar_csc | ar_stat) & channel_event_flag)
        clear_armed <= 1'b1; // RL3
      if (dual_edge_mode & edge_hit)
        dual_edge_seen <= 1'b1;
      else if (flag_clear)
        dual_edge_seen <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // control bits
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_irq_enable <= 1'b0;
      mode_select_hi <= 1'b0;
      mode_select_lo <= 1'b0;
      edge_level_select_hi <= 1'b0;
      edge_level_select_lo <= 1'b0;
      write_protect_disable <= `TCSC_RST_WRITE_PROTECT_DISABLE;
    end
    else
    begin
      if (wr_csc)
        channel_irq_enable <= w_data_q[`TCSC_BIT_IRQ_EN]; // RL6
      if (sel_wr)
      begin
        mode_select_hi <= w_data_q[`TCSC_BIT_MODE_HI]; // RL7
        mode_select_lo <= w_data_q[`TCSC_BIT_MODE_LO]; // RL7
        edge_level_select_hi <= w_data_q[`TCSC_BIT_EDGE_HI]; // RL8
        edge_level_select_lo <= w_data_q[`TCSC_BIT_EDGE_LO]; // RL8
      end
      if (wr_ctrl)
        write_protect_disable <= w_data_q[`TCSC_BIT_WRITE_PROTECT_DISABLE];
    end
  end
endmodule

// ==== test/tcsc_channel_props.sv ====
// port assertions for the channel status-control block
`timescale 1ns/100ps
module tcsc_channel_props
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic channel_event,
  input wire logic dual_edge_mode,
  input wire logic channel_port_enable,
  input wire logic [1:0] mode_select,
  input wire logic [1:0] edge_level_select,
  input wire logic channel_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // register fields move only with the write that lands them
  sequence write_lands;
    $rose(s_axi_bvalid);
  endsequence
  a_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("reserved read bits not zero");
  a_port_enable: assert property (
    channel_port_enable == !(dual_edge_mode && edge_level_select == 2'h0))
    else $error("port enable wrong for edge select");
  a_mode_hold: assert property (
    $changed(mode_select) |-> write_lands)
    else $error("mode select changed without write");
  a_edge_hold: assert property (
    $changed(edge_level_select) |-> write_lands)
    else $error("edge select changed without write");
  a_irq_drop: assert property (
    $fell(channel_irq) |-> write_lands)
    else $error("irq dropped without write");
  a_irq_raise: assert property (
    $rose(channel_irq) |-> ($past(channel_event) || dual_edge_mode)
      or write_lands)
    else $error("irq raised without cause");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule

// ==== test/timer_channel_status_control_test.sv ====
// self-checking bench for the channel status-control block
`timescale 1ns/100ps
module timer_channel_status_control_test;
  logic core_clk = 1'h0, resetn = 1'h0, channel_event = 1'h0;
  logic dual_edge_mode = 1'h0, channel_pin = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, channel_port_enable, channel_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode_select, edge_level_select, rs;
  logic [31:0] s_axi_rdata, rv;
  int num_errors = 0, tests_run = 0, cycles = 0;
  tcsc_channel dut (.*);
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; ceiling far above the few hundred cycles used
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
    s_axi_awaddr <= a; s_axi_wdata <= d;
    fork
      begin
        do @(posedge core_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge core_clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge core_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge core_clk);
    s_axi_arvalid <= 1'h1; s_axi_araddr <= a; s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rv = s_axi_rdata; rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic pulse();
    @(posedge core_clk) channel_event <= 1'h1;
    @(posedge core_clk) channel_event <= 1'h0;
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // protected select bits refuse writes until unlocked
  task automatic t_protect();
    rd(32'h0); chk(rv, 32'h0);
    wr(32'h0, 32'hffffffff); rd(32'h0); chk(rv, 32'h40);
    wr(32'h4, 32'h1); wr(32'h0, 32'h7c); rd(32'h0); chk(rv, 32'h7c);
    chk(mode_select, 2'h3);
    chk(edge_level_select, 2'h3);
  endtask
  // clearing needs read then zero-write, and a new event spoils it
  task automatic t_flag();
    pulse(); chk(channel_irq, 1'h1);
    wr(32'h0, 32'h7c); rd(32'h0); chk(rv, 32'hfc);
    pulse(); wr(32'h0, 32'h7c); rd(32'h0); chk(rv, 32'hfc);
    wr(32'h0, 32'h7c); rd(32'h0); chk(rv, 32'h7c);
    chk(channel_irq, 1'h0);
    wr(32'h0, 32'hfc); rd(32'h0); chk(rv, 32'h7c);
    // a one-write to a set, armed flag must leave it set
    pulse(); rd(32'h8); chk(rv, 32'h1);
    wr(32'h0, 32'hfc); rd(32'h0); chk(rv, 32'hfc);
    wr(32'h0, 32'h7c); rd(32'h0); chk(rv, 32'h7c);
  endtask
  // every edge select code in dual edge capture, both pin directions
  task automatic t_edges();
    dual_edge_mode <= 1'h1;
    for (int e = 0; e < 4; e++)
    begin
      wr(32'h0, e << 2); chk(channel_port_enable, e != 0);
      @(posedge core_clk) channel_pin <= 1'h1;
      repeat (4) @(posedge core_clk);
      rd(32'h0); chk(rv[7], e[0]); wr(32'h0, e << 2);
      @(posedge core_clk) channel_pin <= 1'h0;
      repeat (4) @(posedge core_clk);
      rd(32'h0); chk(rv[7], e[1]); wr(32'h0, e << 2);
    end
  endtask
  // unmapped offset answers with an error and zero data
  task automatic t_unmapped();
    rd(32'hc); chk(rv, 32'h0); chk(rs, 2'h2);
    wr(32'hc, 32'hff); chk(rs, 2'h2);
    // low byte strobe off: the write must change nothing
    s_axi_wstrb <= 4'he;
    wr(32'h0, 32'h0); rd(32'h0); chk(rv, 32'hc);
    s_axi_wstrb <= 4'hf;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset held five cycles, then each scenario in turn
  initial
  begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'h1;
    t_protect();
    t_flag();
    t_edges();
    t_unmapped();
    wrap_up();
  end
endmodule
bind tcsc_channel tcsc_channel_props chk (.*);
